/* vscir_params.svh */
// Register map, field positions, reset values and timing counts of the sync/chroma bank
`ifndef VSCIR_PARAMS_SVH
`define VSCIR_PARAMS_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define VSCIR_OFF_LINE_SYNC_START  8'h16
`define VSCIR_OFF_VBLANK_START     8'h18
`define VSCIR_OFF_VBLANK_STOP      8'h19
`define VSCIR_OFF_CHROMA_CTRL1     8'h1A
`define VSCIR_OFF_CHROMA_CTRL2     8'h1B
`define VSCIR_OFF_INT_CLEAR_B      8'h1C

// ***************************************************************
// Reset values
// ***************************************************************
`define VSCIR_RST_LINE_SYNC_START  8'h80
`define VSCIR_RST_VBLANK_START     8'h00
`define VSCIR_RST_VBLANK_STOP      8'h00
`define VSCIR_RST_CHROMA_CTRL1     8'h0C
`define VSCIR_RST_CHROMA_CTRL2     8'h14

// ***************************************************************
// Field positions
// ***************************************************************
`define VSCIR_CC1_PLL_RESET_BIT    4
`define VSCIR_CC1_ADAPT_COMB_BIT   3
`define VSCIR_CC1_COMB_BIT         2
`define VSCIR_CC1_AUTO_COLOR_GAIN_MODE_LSB         0
`define VSCIR_CC2_WIDE_BIT         2
`define VSCIR_CC2_FSEL_LSB         0
`define VSCIR_INT_TV_VCR_BIT       0
`define VSCIR_INT_RESERVED_MASK    8'hDF

// ***************************************************************
// Timing counts in sample clocks and lines
// ***************************************************************
`define VSCIR_SYNC_CODE_ZERO       8'h80
`define VSCIR_SYNC_STEP            4
`define VSCIR_HB_TO_SYNC_525       28
`define VSCIR_HB_TO_SYNC_625       32
`define VSCIR_HB_LEN_525           272
`define VSCIR_HB_LEN_625           284
`define VSCIR_FRAME_LINES_525      525
`define VSCIR_FRAME_LINES_625      625

`endif

/* vscir_pkg.sv */
// Types shared by the sync/chroma register bank
package vscir_pkg;

  typedef enum logic [1:0] {
    VSCIR_AUTO_COLOR_GAIN_MODE_ON     = 2'h0,
    VSCIR_AUTO_COLOR_GAIN_MODE_RSVD   = 2'h1,
    VSCIR_AUTO_COLOR_GAIN_MODE_OFF    = 2'h2,
    VSCIR_AUTO_COLOR_GAIN_MODE_FROZEN = 2'h3
  } vscir_auto_color_gain_mode_t;

  typedef struct packed {
    logic [7:0]  sync_off;
    logic [7:0]  vbs_off;
    logic [7:0]  vbe_off;
    logic [7:0]  cc1;
    logic [7:0]  cc2;
    logic [7:0]  sync_sh;
    logic [7:0]  vbs_sh;
    logic [7:0]  vbe_sh;
    logic [11:0] pix;
    logic [11:0] line;
    logic [11:0] frame_lines;
    logic        vcr;
    logic [7:0]  sts;
    logic        genlock_control_out_pend;
    logic        genlock_control_out_act;
    logic        pll_rst;
    logic [7:0]  rdata;
    logic        line_sync;
    logic        vblank;
    logic        bypass;
    logic        shared_pin;
    logic        genlock_pin;
    logic        irq;
  } vscir_state_t;

endpackage

/* vscir_regs.sv */
// Sync offset, vertical blanking, chroma control and interrupt clear register bank
`timescale 1ns/1ns
`include "vscir_params.svh"
module vscir_regs #(
  parameter int VBI_START_LINE = 1,
  parameter int VBI_STOP_LINE  = 21,
  parameter int SYNC_WIDTH     = 64,
  parameter int LINE_LEN_525   = 1716,
  parameter int LINE_LEN_625   = 1728
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port from the serial bus front end
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  // Video timing from the decoder core
  input  wire logic        std_625_i,
  input  wire logic        line_start_i,
  input  wire logic        field_start_i,
  input  wire logic        field_identifier_i,
  input  wire logic [7:0]  int_event_i,
  // Pin configuration from other register banks
  input  wire logic        shared_pin_sel_i,
  input  wire logic        shared_blank_sel_i,
  input  wire logic        genlock_sel_i,
  input  wire logic        general_purpose_control_i,
  input  wire logic [7:0]  int_enable_b_i,
  // Timing outputs
  output logic             line_sync_o,
  output logic             vertical_blank_out_o,
  output logic             luma_bypass_o,
  output logic             shared_irq_gp_blank_pin_o,
  output logic             genlock_field_pin_o,
  output logic             interrupt_request_out_o,
  // Chroma controls
  output logic             color_pll_reset_o,
  output logic             adaptive_comb_enable_o,
  output logic             comb_enable_o,
  output logic [1:0]       auto_color_gain_mode_o,
  output logic             wide_chroma_filter_o,
  output logic [1:0]       chroma_filter_sel_o,
  // Status
  output logic [7:0]       int_status_b_o,
  output logic             vcr_mode_o
);

  // ***************************************************************
  // State
  // ***************************************************************
  vscir_pkg::vscir_state_t q;
  vscir_pkg::vscir_state_t d;

  logic signed [12:0] sync_pos;
  logic signed [12:0] blank_start;
  logic signed [12:0] blank_stop;
  logic signed [12:0] line_s;
  logic        [11:0] line_len;
  logic        [11:0] hb_to_sync;
  logic        [11:0] frame_std;
  logic        [7:0]  set_mask;
  logic        [7:0]  clr_mask;
  logic               in_blank;
  logic               vcr_now;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    d = q;
    line_len   = std_625_i ? 12'(LINE_LEN_625) : 12'(LINE_LEN_525);
    hb_to_sync = std_625_i ? 12'(`VSCIR_HB_TO_SYNC_625)
                           : 12'(`VSCIR_HB_TO_SYNC_525);
    frame_std  = std_625_i ? 12'(`VSCIR_FRAME_LINES_625)
                           : 12'(`VSCIR_FRAME_LINES_525);

    // Register writes
    // Unmapped offsets match no branch and change nothing
    d.pll_rst = 1'b0;
    clr_mask  = 8'h00;
    if (reg_wr_i)
    begin
      if (reg_addr_i == `VSCIR_OFF_LINE_SYNC_START)
      begin
        d.sync_off = reg_wdata_i;
      end
      else if (reg_addr_i == `VSCIR_OFF_VBLANK_START)
      begin
        d.vbs_off = reg_wdata_i;
      end
      else if (reg_addr_i == `VSCIR_OFF_VBLANK_STOP)
      begin
        d.vbe_off = reg_wdata_i;
      end
      else if (reg_addr_i == `VSCIR_OFF_CHROMA_CTRL1)
      begin
        // The PLL reset bit is a strobe and is never stored
        d.cc1 = reg_wdata_i & ~(8'h01 << `VSCIR_CC1_PLL_RESET_BIT);
        d.pll_rst = reg_wdata_i[`VSCIR_CC1_PLL_RESET_BIT];
      end
      else if (reg_addr_i == `VSCIR_OFF_CHROMA_CTRL2)
      begin
        d.cc2 = reg_wdata_i;
      end
      else if (reg_addr_i == `VSCIR_OFF_INT_CLEAR_B)
      begin
        clr_mask = reg_wdata_i;
      end
    end

    // Read data: write-only and unmapped offsets read as zero
    if (reg_rd_i)
    begin
      if (reg_addr_i == `VSCIR_OFF_LINE_SYNC_START)
      begin
        d.rdata = q.sync_off;
      end
      else if (reg_addr_i == `VSCIR_OFF_VBLANK_START)
      begin
        d.rdata = q.vbs_off;
      end
      else if (reg_addr_i == `VSCIR_OFF_VBLANK_STOP)
      begin
        d.rdata = q.vbe_off;
      end
      else if (reg_addr_i == `VSCIR_OFF_CHROMA_CTRL1)
      begin
        d.rdata = q.cc1;
      end
      else if (reg_addr_i == `VSCIR_OFF_CHROMA_CTRL2)
      begin
        d.rdata = q.cc2;
      end
      else
      begin
        d.rdata = 8'h00;
      end
    end

    // Pixel and line counters; shadows load at boundaries so no pulse is cut short
    if (line_start_i)
    begin
      d.pix     = 12'h000;
      d.sync_sh = q.sync_off;
      d.line    = q.line + 12'h001;
      d.frame_lines = q.frame_lines + 12'h001;
    end
    else
    begin
      d.pix = q.pix + 12'h001;
    end
    if (field_start_i)
    begin
      d.line   = 12'h000;
      d.vbs_sh = q.vbs_off;
      d.vbe_sh = q.vbe_off;
    end

    // Line sync: shift = (128 - code) * 4 from the nominal blank-to-sync point
    sync_pos = $signed({1'b0, hb_to_sync})
             + ($signed({5'h00, `VSCIR_SYNC_CODE_ZERO})
             - $signed({5'h00, q.sync_sh})) * 13'sd4;
    // A negative position lands in the tail of the line
    if (sync_pos < 0)
    begin
      sync_pos = sync_pos + $signed({1'b0, line_len});
    end
    if ($signed({1'b0, q.pix}) == sync_pos)
    begin
      d.line_sync = 1'b1;
    end
    else if ($signed({1'b0, q.pix}) == sync_pos + 13'(SYNC_WIDTH) || line_start_i)
    begin
      d.line_sync = 1'b0;
    end

    // Vertical blanking window, offsets are signed lines
    line_s      = $signed({1'b0, q.line});
    blank_start = 13'(VBI_START_LINE) + 13'($signed(q.vbs_sh));
    blank_stop  = 13'(VBI_STOP_LINE) + 13'($signed(q.vbe_sh));
    in_blank    = (line_s >= blank_start) && (line_s < blank_stop);
    d.vblank    = in_blank;
    d.bypass    = in_blank;

    // Lines per frame decide TV or VCR mode at each frame start
    vcr_now = q.vcr;
    if (field_start_i && !field_identifier_i)
    begin
      // The frame's first line is counted too, or a standard frame would read one short
      if (line_start_i)
      begin
        d.frame_lines = 12'h001;
      end
      else
      begin
        d.frame_lines = 12'h000;
      end
      vcr_now = (q.frame_lines != frame_std);
      d.vcr = vcr_now;
    end

    // Sticky status, a new event wins over a clear in the same cycle
    set_mask = int_event_i;
    set_mask[`VSCIR_INT_TV_VCR_BIT] = int_event_i[`VSCIR_INT_TV_VCR_BIT] | (vcr_now != q.vcr);
    d.sts = ((q.sts & ~clr_mask) | set_mask) & `VSCIR_INT_RESERVED_MASK;
    // Request is active high only; no open-drain mode is modelled
    d.irq = |(q.sts & int_enable_b_i);

    // Phase reset indication rides the whole of the following line
    if (q.pll_rst)
    begin
      d.genlock_control_out_pend = 1'b1;
    end
    if (line_start_i)
    begin
      d.genlock_control_out_act  = q.genlock_control_out_pend | q.pll_rst;
      d.genlock_control_out_pend = 1'b0;
    end

    // Pin muxes
    // Registered muxes: each pin trails its source by one clock
    if (!shared_pin_sel_i)
    begin
      d.shared_pin = q.irq;
    end
    else if (shared_blank_sel_i)
    begin
      d.shared_pin = q.vblank;
    end
    else
    begin
      d.shared_pin = general_purpose_control_i;
    end
    d.genlock_pin = genlock_sel_i ? q.genlock_control_out_act : field_identifier_i;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q          <= '0;
      // Shadows start equal to their registers, so the first line is regular
      q.sync_off <= `VSCIR_RST_LINE_SYNC_START;
      q.vbs_off  <= `VSCIR_RST_VBLANK_START;
      q.vbe_off  <= `VSCIR_RST_VBLANK_STOP;
      q.cc1      <= `VSCIR_RST_CHROMA_CTRL1;
      q.cc2      <= `VSCIR_RST_CHROMA_CTRL2;
      q.sync_sh  <= `VSCIR_RST_LINE_SYNC_START;
      q.vbs_sh   <= `VSCIR_RST_VBLANK_START;
      q.vbe_sh   <= `VSCIR_RST_VBLANK_STOP;
    end
    else
    begin
      q <= d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // All outputs are state bits, so no pin can glitch
  assign reg_rdata_o               = q.rdata;
  assign line_sync_o               = q.line_sync;
  assign vertical_blank_out_o      = q.vblank;
  assign luma_bypass_o             = q.bypass;
  assign shared_irq_gp_blank_pin_o = q.shared_pin;
  assign genlock_field_pin_o       = q.genlock_pin;
  assign interrupt_request_out_o   = q.irq;
  assign color_pll_reset_o         = q.pll_rst;
  assign adaptive_comb_enable_o    = q.cc1[`VSCIR_CC1_ADAPT_COMB_BIT];
  assign comb_enable_o             = q.cc1[`VSCIR_CC1_COMB_BIT];
  assign auto_color_gain_mode_o    = q.cc1[`VSCIR_CC1_AUTO_COLOR_GAIN_MODE_LSB +: 2];
  assign wide_chroma_filter_o      = q.cc2[`VSCIR_CC2_WIDE_BIT];
  assign chroma_filter_sel_o       = q.cc2[`VSCIR_CC2_FSEL_LSB +: 2];
  assign int_status_b_o            = q.sts;
  assign vcr_mode_o                = q.vcr;

endmodule

/* vscir_host.sv */
// Host model reaching the bank through its decoded byte port
`timescale 1ns/1ns
module vscir_host (
  // Clock and read data
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  // Request lines
  output logic            wr_o,
  output logic            rd_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o
);
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // Released address and data lines turn to their inverse, so a stale value never passes
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(1'b0, a, 8'h00);
    d = rdata_i;
  endtask
endmodule

/* vscir_regs_assertions.sv */
// Checker on the ports of the sync/chroma register bank
`timescale 1ns/1ns
module vscir_regs_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       line_start_i,
  input wire logic       field_start_i,
  input wire logic [7:0] int_event_i,
  input wire logic [7:0] int_enable_b_i,
  input wire logic       shared_pin_sel_i,
  input wire logic       shared_blank_sel_i,
  input wire logic       general_purpose_control_i,
  input wire logic       vertical_blank_out_o,
  input wire logic       luma_bypass_o,
  input wire logic       shared_irq_gp_blank_pin_o,
  input wire logic       interrupt_request_out_o,
  input wire logic       color_pll_reset_o,
  input wire logic       adaptive_comb_enable_o,
  input wire logic       comb_enable_o,
  input wire logic [1:0] auto_color_gain_mode_o,
  input wire logic       wide_chroma_filter_o,
  input wire logic [1:0] chroma_filter_sel_o,
  input wire logic [7:0] int_status_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence cc1_wr; reg_wr_i && reg_addr_i == 8'h1A; endsequence
  sequence cc2_wr; reg_wr_i && reg_addr_i == 8'h1B; endsequence
  sequence clr_wr;
    reg_wr_i && reg_addr_i == 8'h1C && int_event_i == 8'h00 && !field_start_i;
  endsequence
  chroma_one_a: assert property (
    cc1_wr |=> {adaptive_comb_enable_o, comb_enable_o, auto_color_gain_mode_o}
    == $past(reg_wdata_i[3:0])) else $error("chroma control 1 outputs wrong");
  pll_pulse_a: assert property (
    cc1_wr ##0 reg_wdata_i[4] |=> color_pll_reset_o) else $error("no pll reset pulse");
  chroma_two_a: assert property (
    cc2_wr |=> {wide_chroma_filter_o, chroma_filter_sel_o} == $past(reg_wdata_i[2:0]))
    else $error("chroma control 2 outputs wrong");
  status_clear_a: assert property (
    clr_wr |=> (int_status_b_o & $past(reg_wdata_i)) == 8'h00) else $error("status not cleared");
  reserved_bit_a: assert property (
    int_status_b_o[5] == 1'b0) else $error("reserved status bit set");
  irq_mask_a: assert property (
    1'b1 |=> interrupt_request_out_o == |($past(int_status_b_o) & $past(int_enable_b_i)))
    else $error("interrupt request wrong");
  pin_irq_a: assert property (
    !shared_pin_sel_i |=> shared_irq_gp_blank_pin_o == $past(interrupt_request_out_o))
    else $error("shared pin not showing request");
  bypass_window_a: assert property (
    luma_bypass_o == vertical_blank_out_o) else $error("bypass window differs");
  pin_blank_a: assert property (
    shared_pin_sel_i && shared_blank_sel_i
    |=> shared_irq_gp_blank_pin_o == $past(vertical_blank_out_o))
    else $error("shared pin not showing blanking");
  pin_gp_a: assert property (
    shared_pin_sel_i && !shared_blank_sel_i
    |=> shared_irq_gp_blank_pin_o == $past(general_purpose_control_i))
    else $error("shared pin not showing control level");
  blank_step_a: assert property (
    $changed(vertical_blank_out_o) |-> $past(line_start_i, 2) || $past(field_start_i, 2))
    else $error("blanking changed off a line boundary");
endmodule
bind vscir_regs vscir_regs_chk i_chk (
  .clk_i                    (clk_i),
  .rst_i                    (rst_i),
  .reg_wr_i                 (reg_wr_i),
  .reg_addr_i               (reg_addr_i),
  .reg_wdata_i              (reg_wdata_i),
  .line_start_i             (line_start_i),
  .field_start_i            (field_start_i),
  .int_event_i              (int_event_i),
  .int_enable_b_i           (int_enable_b_i),
  .shared_pin_sel_i         (shared_pin_sel_i),
  .shared_blank_sel_i       (shared_blank_sel_i),
  .general_purpose_control_i(general_purpose_control_i),
  .vertical_blank_out_o     (vertical_blank_out_o),
  .luma_bypass_o            (luma_bypass_o),
  .shared_irq_gp_blank_pin_o(shared_irq_gp_blank_pin_o),
  .interrupt_request_out_o  (interrupt_request_out_o),
  .color_pll_reset_o        (color_pll_reset_o),
  .adaptive_comb_enable_o   (adaptive_comb_enable_o),
  .comb_enable_o            (comb_enable_o),
  .auto_color_gain_mode_o   (auto_color_gain_mode_o),
  .wide_chroma_filter_o     (wide_chroma_filter_o),
  .chroma_filter_sel_o      (chroma_filter_sel_o),
  .int_status_b_o           (int_status_b_o)
);

/* tb.sv */
// Self-checking testbench for the sync/chroma register bank
`timescale 1ns/1ns
module tb;
  logic        clk_i = 1'b0;
  logic        rst_i, reg_wr_i, reg_rd_i, std_625_i, line_start_i, field_start_i;
  logic        field_identifier_i, shared_pin_sel_i, shared_blank_sel_i, genlock_sel_i;
  logic        general_purpose_control_i, line_sync_o, vertical_blank_out_o, luma_bypass_o;
  logic        shared_irq_gp_blank_pin_o, genlock_field_pin_o, interrupt_request_out_o;
  logic        color_pll_reset_o, adaptive_comb_enable_o, comb_enable_o;
  logic        wide_chroma_filter_o, vcr_mode_o;
  logic [1:0]  auto_color_gain_mode_o, chroma_filter_sel_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, int_event_i, int_enable_b_i;
  logic [7:0]  int_status_b_o, g;
  logic [15:0] t;
  int          fail_count = 0;
  int          n_tests = 0;
  logic [7:0]  ra [7] = '{8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h17};
  logic [7:0]  re [7] = '{8'h80, 8'h00, 8'h00, 8'h0C, 8'h14, 8'h00, 8'h00};
  logic [7:0]  sc [4] = '{8'h80, 8'h7F, 8'h00, 8'h80};
  logic [15:0] se [4] = '{16'h001E, 16'h0022, 16'h021E, 16'h0022};
  vscir_regs i_dut (
    .clk_i                    (clk_i),
    .rst_i                    (rst_i),
    .reg_wr_i                 (reg_wr_i),
    .reg_rd_i                 (reg_rd_i),
    .reg_addr_i               (reg_addr_i),
    .reg_wdata_i              (reg_wdata_i),
    .reg_rdata_o              (reg_rdata_o),
    .std_625_i                (std_625_i),
    .line_start_i             (line_start_i),
    .field_start_i            (field_start_i),
    .field_identifier_i       (field_identifier_i),
    .int_event_i              (int_event_i),
    .shared_pin_sel_i         (shared_pin_sel_i),
    .shared_blank_sel_i       (shared_blank_sel_i),
    .genlock_sel_i            (genlock_sel_i),
    .general_purpose_control_i(general_purpose_control_i),
    .int_enable_b_i           (int_enable_b_i),
    .line_sync_o              (line_sync_o),
    .vertical_blank_out_o     (vertical_blank_out_o),
    .luma_bypass_o            (luma_bypass_o),
    .shared_irq_gp_blank_pin_o(shared_irq_gp_blank_pin_o),
    .genlock_field_pin_o      (genlock_field_pin_o),
    .interrupt_request_out_o  (interrupt_request_out_o),
    .color_pll_reset_o        (color_pll_reset_o),
    .adaptive_comb_enable_o   (adaptive_comb_enable_o),
    .comb_enable_o            (comb_enable_o),
    .auto_color_gain_mode_o   (auto_color_gain_mode_o),
    .wide_chroma_filter_o     (wide_chroma_filter_o),
    .chroma_filter_sel_o      (chroma_filter_sel_o),
    .int_status_b_o           (int_status_b_o),
    .vcr_mode_o               (vcr_mode_o)
  );
  vscir_host i_host (.clk_i(clk_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  always #4 clk_i = ~clk_i;
  // *****
  // Tasks
  // *****
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk("rdata", 16'(e), 16'(d));
  endtask
  // One line; t is the cycle of the first sync rise, g the pins at cycle 100
  task automatic line(input logic f);
    @(negedge clk_i);
    line_start_i = 1'b1;
    field_start_i = f;
    t = 16'h0000;
    for (int i = 1; i < 1716; i++)
    begin
      @(negedge clk_i);
      line_start_i = 1'b0;
      field_start_i = 1'b0;
      if (line_sync_o === 1'b1 && t == 16'h0000)
        t = 16'(i);
      if (i == 100)
        g = {4'h0, luma_bypass_o, genlock_field_pin_o, vertical_blank_out_o,
             shared_irq_gp_blank_pin_o};
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // *****
  // Main sequence
  // *****
  initial
  begin
    #(8 * 90000);
    fail_count++;
    end_of_test();
  end
  initial
  begin
    rst_i = 1'b1;
    {std_625_i, line_start_i, field_start_i, field_identifier_i} = 4'h0;
    {shared_pin_sel_i, shared_blank_sel_i, genlock_sel_i, general_purpose_control_i} = 4'h0;
    int_event_i = 8'h00;
    int_enable_b_i = 8'h00;
    g = 8'h00;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    i_host.wr(8'h17, 8'hFF);
    foreach (ra[k])
      rchk(ra[k], re[k]);
    for (int k = 0; k < 16; k++)
    begin
      i_host.wr(8'h1A, 8'(k));
      chk("cc1", 16'(k), 16'({adaptive_comb_enable_o, comb_enable_o, auto_color_gain_mode_o}));
      rchk(8'h1A, 8'(k));
      i_host.wr(8'h1B, 8'(k[2:0]));
      chk("cc2", 16'(k[2:0]), 16'({wide_chroma_filter_o, chroma_filter_sel_o}));
    end
    i_host.wr(8'h1A, 8'h1C);
    chk("pll", 16'h0001, 16'(color_pll_reset_o));
    rchk(8'h1A, 8'h0C);
    genlock_sel_i = 1'b1;
    line(1'b0);
    chk("genlock_control_out", 16'h0004, 16'(g & 8'h04));
    line(1'b0);
    chk("genlock_control_out", 16'h0000, 16'(g & 8'h04));
    genlock_sel_i = 1'b0;
    field_identifier_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("fid pin", 16'h0001, 16'(genlock_field_pin_o));
    foreach (sc[k])
    begin
      std_625_i = 1'(k == 3);
      i_host.wr(8'h16, sc[k]);
      line(1'b0);
      line(1'b0);
      chk("sync", se[k], t);
    end
    std_625_i = 1'b0;
    field_identifier_i = 1'b0;
    i_host.wr(8'h18, 8'h02);
    i_host.wr(8'h19, 8'hFF);
    {shared_pin_sel_i, shared_blank_sel_i} = 2'h3;
    for (int n = 0; n < 23; n++)
    begin
      line(1'(n == 0));
      chk("blank", 16'({2{n >= 3 && n < 20}}), 16'(g[1:0]));
      chk("bypass", 16'(n >= 3 && n < 20), 16'(g[3]));
    end
    line(1'b1);
    chk("vcr", 16'h0003, 16'({vcr_mode_o, int_status_b_o[0]}));
    shared_pin_sel_i = 1'b0;
    int_enable_b_i = 8'h04;
    i_host.wr(8'h1C, 8'hFF);
    int_event_i = 8'hFF;
    @(negedge clk_i);
    int_event_i = 8'h00;
    chk("status", 16'h00DF, 16'(int_status_b_o));
    repeat (2) @(negedge clk_i);
    chk("irq pin", 16'h0003, 16'({interrupt_request_out_o, shared_irq_gp_blank_pin_o}));
    i_host.wr(8'h1C, 8'h04);
    chk("status", 16'h00DB, 16'(int_status_b_o));
    repeat (2) @(negedge clk_i);
    chk("irq pin", 16'h0000, 16'({interrupt_request_out_o, shared_irq_gp_blank_pin_o}));
    {shared_pin_sel_i, shared_blank_sel_i, general_purpose_control_i} = 3'h5;
    repeat (2) @(negedge clk_i);
    chk("gp pin", 16'h0001, 16'(shared_irq_gp_blank_pin_o));
    end_of_test();
  end
endmodule
